// *** verilog/aes_irq_accept.sv ***
/*
  Interrupt acceptance: external edge select, status word with global
  enable, request and mask flags, and the accept sequence that pushes
  the status word and program counter and loads the vector.
  Assumes a CPU core on the same clock that flags the last clock of each
  instruction, stalls while cpuHold is high and performs the stack writes.
*/
module aes_irq_accept
  import aes_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  extIrqPinA,
  input  wire logic                  extIrqPinB,
  input  wire logic                  extIrqPinC,
  input  wire logic [NUM_SRC-1:0]    periphReq,
  input  wire logic                  nmiReq,
  input  wire aes_reg_sel_type       regSel,
  input  wire logic                  regWrEn,
  input  wire logic                  regRdEn,
  input  wire logic [7:0]            regWrData,
  output logic      [7:0]            regRdData,
  input  wire logic                  enableIrqInstr,
  input  wire logic                  disableIrqInstr,
  input  wire logic                  pswRestoreEn,
  input  wire logic [7:0]            pswRestoreData,
  input  wire logic                  aluFlagWe,
  input  wire logic                  aluZero,
  input  wire logic                  aluAuxCarry,
  input  wire logic                  aluCarry,
  input  wire logic                  instrLast,
  input  wire logic                  instrTouchesIrqRegs,
  input  wire logic [15:0]           pcIn,
  output logic                       globalIrqEnable,
  output logic                       cpuHold,
  output logic                       stackWrEn,
  output logic                       stackWrIsPsw,
  output logic      [15:0]           stackWrData,
  output logic                       pcLoad,
  output logic      [3:0]            vectorIdx,
  output logic                       haltWake
);

  logic [7:0]         edgeMode_q;
  logic [7:0]         psw_q;
  logic [NUM_SRC-1:0] req_q;
  logic [NUM_SRC-1:0] req_d;
  logic [NUM_SRC-1:0] mask_q;
  logic [NUM_SRC-1:0] mask_d;
  logic               nmiPend_q;
  logic               deferNext_q;
  logic [7:0]         pswSnap_q;
  logic [3:0]         vecSel_q;
  aes_seq_type        state_q;
  aes_seq_type        state_d;
  logic [NUM_PINS-1:0] pinEdge;
  logic [NUM_SRC-1:0] reqEvent;
  logic [NUM_SRC-1:0] ackClr;
  logic               boundaryOk;
  logic               acceptNmi;
  logic               acceptMask;
  logic               acceptAny;
  logic [7:0]         reqLowRd;
  logic [7:0]         reqHighRd;
  logic [7:0]         maskLowRd;
  logic [7:0]         maskHighRd;

  aes_pick_if pick ();

  aes_edge_detect uEdge (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .pinIn     ({extIrqPinC, extIrqPinB, extIrqPinA}),
    .edgeSel   (edgeMode_q[7:EDGE_A_LSB]),
    .edgePulse (pinEdge)
  );

  aes_prio_pick uPick (
    .pick (pick.picker)
  );

  // Pin edges join the peripheral requests at the pin sources
  always_comb begin
    reqEvent = periphReq;
    reqEvent[SRC_PIN_A +: NUM_PINS] =
      periphReq[SRC_PIN_A +: NUM_PINS] | pinEdge;
  end

  // Edge mode register; the two lowest bits are held at zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      edgeMode_q <= EDGE_MODE_RESET;
    end else if (regWrEn && regSel == SEL_EDGE_MODE) begin
      edgeMode_q <= regWrData & EDGE_MODE_WMASK;
    end
  end

  // Status word. Accept clears enable last so it wins over EI.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      psw_q <= PSW_RESET;
    end else begin
      if (regWrEn && regSel == SEL_PSW) begin
        psw_q <= (regWrData & PSW_WMASK) | PSW_FIXED;
      end else if (pswRestoreEn) begin
        psw_q <= (pswRestoreData & PSW_WMASK) | PSW_FIXED;
      end else begin
        if (aluFlagWe) begin
          psw_q[PSW_Z]  <= aluZero;
          psw_q[PSW_AC] <= aluAuxCarry;
          psw_q[PSW_CY] <= aluCarry;
        end
        if (enableIrqInstr) begin
          psw_q[PSW_IE] <= 1'b1;
        end else if (disableIrqInstr) begin
          psw_q[PSW_IE] <= 1'b0;
        end
      end
      if (acceptAny) begin
        psw_q[PSW_IE] <= 1'b0;
      end
    end
  end

  assign globalIrqEnable = psw_q[PSW_IE];

  // Request flags: a new event wins over a write or accept clear
  always_comb begin
    req_d = req_q;
    if (regWrEn && regSel == SEL_REQ_LOW) begin
      req_d[7:0] = regWrData;
    end
    if (regWrEn && regSel == SEL_REQ_HIGH) begin
      req_d[NUM_SRC-1:8] = regWrData[NUM_SRC-9:0];
    end
    req_d = (req_d & ~ackClr) | reqEvent;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      req_q <= {1'b0, REQ_RESET};
    end else begin
      req_q <= req_d;
    end
  end

  always_comb begin
    mask_d = mask_q;
    if (regWrEn && regSel == SEL_MASK_LOW) begin
      mask_d[7:0] = regWrData;
    end
    if (regWrEn && regSel == SEL_MASK_HIGH) begin
      mask_d[NUM_SRC-1:8] = regWrData[NUM_SRC-9:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= {NUM_SRC{1'b1}};
    end else begin
      mask_q <= mask_d;
    end
  end

  // Non-maskable request is a sticky pending bit; a new one wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      nmiPend_q <= 1'b0;
    end else if (nmiReq) begin
      nmiPend_q <= 1'b1;
    end else if (acceptNmi) begin
      nmiPend_q <= 1'b0;
    end
  end

  // A touch anywhere in the instruction blocks its own boundary only;
  // the next instruction's end may accept again
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      deferNext_q <= 1'b0;
    end else if (instrLast) begin
      deferNext_q <= 1'b0;
    end else if (instrTouchesIrqRegs) begin
      deferNext_q <= 1'b1;
    end
  end

  assign pick.eligible = req_q & ~mask_q;

  // Registered flags only: one set in the last clock misses this boundary
  assign boundaryOk = instrLast && (state_q == ST_IDLE)
                      && !instrTouchesIrqRegs && !deferNext_q;
  assign acceptNmi  = boundaryOk && nmiPend_q;
  assign acceptMask = boundaryOk && !nmiPend_q && pick.valid
                      && psw_q[PSW_IE];
  assign acceptAny  = acceptNmi | acceptMask;

  always_comb begin
    ackClr = '0;
    if (acceptMask) begin
      ackClr[pick.index] = 1'b1;
    end
  end

  // Snapshot of status word and vector taken before enable drops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pswSnap_q <= PSW_RESET;
      vecSel_q  <= VEC_NMI;
    end else if (acceptNmi) begin
      pswSnap_q <= psw_q;
      vecSel_q  <= VEC_NMI;
    end else if (acceptMask) begin
      pswSnap_q <= psw_q;
      vecSel_q  <= pick.index + 4'h1;
    end
  end

  always_comb begin
    case (state_q)
      ST_IDLE:     state_d = acceptAny ? ST_PUSH_PSW : ST_IDLE;
      ST_PUSH_PSW: state_d = ST_PUSH_PC;
      ST_PUSH_PC:  state_d = ST_LOAD_VEC;
      ST_LOAD_VEC: state_d = ST_IDLE;
      default:     state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Stack and vector outputs, status word strictly before the counter
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stackWrEn    <= 1'b0;
      stackWrIsPsw <= 1'b0;
      stackWrData  <= 16'h0000;
      pcLoad       <= 1'b0;
      vectorIdx    <= 4'h0;
    end else begin
      stackWrEn    <= (state_d == ST_PUSH_PSW)
                      || (state_d == ST_PUSH_PC);
      stackWrIsPsw <= (state_d == ST_PUSH_PSW);
      pcLoad       <= (state_d == ST_LOAD_VEC);
      if (state_d == ST_PUSH_PSW) begin
        stackWrData <= {8'h00, (acceptAny ? psw_q : pswSnap_q)};
      end else if (state_d == ST_PUSH_PC) begin
        stackWrData <= pcIn;
      end
      if (state_d == ST_LOAD_VEC) begin
        vectorIdx <= vecSel_q;
      end
    end
  end

  assign cpuHold = (state_q != ST_IDLE);

  // Wakes a halted core whatever the enable; maskable vectoring still needs it, the non-maskable one does not
  assign haltWake = nmiPend_q || (|pick.eligible);

  // Unused flag bits read 0, unused mask bits read 1
  always_comb begin
    reqLowRd   = req_q[7:0];
    reqHighRd  = 8'h00;
    reqHighRd[NUM_SRC-9:0] = req_q[NUM_SRC-1:8];
    maskLowRd  = mask_q[7:0];
    maskHighRd = MASK_RESET;
    maskHighRd[NUM_SRC-9:0] = mask_q[NUM_SRC-1:8];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      case (regSel)
        SEL_EDGE_MODE: regRdData <= edgeMode_q;
        SEL_PSW:       regRdData <= psw_q;
        SEL_REQ_LOW:   regRdData <= reqLowRd;
        SEL_REQ_HIGH:  regRdData <= reqHighRd;
        SEL_MASK_LOW:  regRdData <= maskLowRd;
        SEL_MASK_HIGH: regRdData <= maskHighRd;
        default:       regRdData <= 8'h00;
      endcase
    end
  end

endmodule

// *** verilog/aes_pkg.sv ***
/*
  Constants and types shared by the interrupt acceptance and edge select
  logic. Assumes one CPU clock and a CPU core that talks to it directly.
*/
package aes_pkg;

  localparam int NUM_SRC   = 9;
  localparam int SRC_IDX_W = 4;
  localparam int NUM_PINS  = 3;

  // Register selects on the core's register port
  typedef enum logic [2:0] {
    SEL_EDGE_MODE = 3'h0,
    SEL_PSW       = 3'h1,
    SEL_REQ_LOW   = 3'h2,
    SEL_REQ_HIGH  = 3'h3,
    SEL_MASK_LOW  = 3'h4,
    SEL_MASK_HIGH = 3'h5
  } aes_reg_sel_type;

  localparam logic [7:0] EDGE_MODE_RESET = 8'h00;
  localparam logic [7:0] EDGE_MODE_WMASK = 8'hfc;
  localparam int         EDGE_A_LSB      = 2;
  localparam int         EDGE_FIELD_W    = 2;

  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [7:0] PSW_RESET = 8'h02;
  localparam logic [7:0] PSW_WMASK = 8'hd1;
  localparam logic [7:0] PSW_FIXED = 8'h02;
  localparam int         PSW_IE    = 7;
  localparam int         PSW_Z     = 6;
  localparam int         PSW_AC    = 4;
  localparam int         PSW_CY    = 0;

  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] REQ_RESET  = 8'h00;

  // Request sources fed by the three external pins
  localparam int SRC_PIN_A = 1;

  // Default priority, first entry highest; change to reorder
  localparam logic [SRC_IDX_W-1:0] PRIO_ORDER [NUM_SRC] = '{
    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8
  };

  localparam logic [3:0] VEC_NMI = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_PUSH_PSW = 2'b01,
    ST_PUSH_PC  = 2'b10,
    ST_LOAD_VEC = 2'b11
  } aes_seq_type;

endpackage

// *** verilog/aes_pick_if.sv ***
/*
  Carrier between the acceptance logic and the priority picker.
  Assumes both ends run on the same CPU clock.
*/
interface aes_pick_if;
  import aes_pkg::*;

  logic [NUM_SRC-1:0]   eligible;
  logic                 valid;
  logic [SRC_IDX_W-1:0] index;

  modport requester (output eligible, input valid, input index);
  modport picker    (input eligible, output valid, output index);
endinterface

// *** verilog/aes_edge_detect.sv ***
/*
  Synchronises the three external interrupt pins and reports the
  selected edge of each as a one-cycle pulse. Assumes asynchronous pins.
*/
module aes_edge_detect
  import aes_pkg::*;
(
  input  wire logic                         core_clk,
  input  wire logic                         nrst,
  input  wire logic [NUM_PINS-1:0]          pinIn,
  input  wire logic [NUM_PINS*2-1:0]        edgeSel,
  output logic      [NUM_PINS-1:0]          edgePulse
);

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : gPin
      logic       s1_q, s2_q, s3_q, lvl_q;
      logic [1:0] sel;
      logic       rise, fall;

      assign sel = edgeSel[g*2 +: 2];

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= pinIn[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end

      // Level moves only once two stages agree, so one edge counts once
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          lvl_q <= 1'b0;
        end else if (s2_q == s3_q) begin
          lvl_q <= s3_q;
        end
      end

      assign rise = (s2_q == s3_q) && s3_q && !lvl_q;
      assign fall = (s2_q == s3_q) && !s3_q && lvl_q;

      always_comb begin
        case (sel)
          EDGE_FALL: edgePulse[g] = fall;
          EDGE_RISE: edgePulse[g] = rise;
          EDGE_BOTH: edgePulse[g] = rise | fall;
          default:   edgePulse[g] = 1'b0;
        endcase
      end
    end
  endgenerate

endmodule

// *** verilog/aes_prio_pick.sv ***
/*
  Picks the highest priority eligible maskable source using the fixed
  default order. Purely combinational; assumes the carrier interface.
*/
module aes_prio_pick
  import aes_pkg::*;
(
  aes_pick_if.picker pick
);

  always_comb begin
    pick.valid = 1'b0;
    pick.index = '0;
    // Walk from lowest priority up so the highest one wins
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pick.eligible[PRIO_ORDER[i]]) begin
        pick.valid = 1'b1;
        pick.index = PRIO_ORDER[i];
      end
    end
  end

endmodule

// *** testbench/aes_cpu_model.sv ***
/*
  Behavioural CPU core for the acceptance block: fixed-length
  instructions, stalls while held, jumps on a vector load.
  Assumes the block samples on the rising edge of core_clk.
*/
module aes_cpu_model
  import aes_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  instrLen,
  input  wire logic        cpuHold,
  input  wire logic        pcLoad,
  input  wire logic [3:0]  vectorIdx,
  output logic             instrLast,
  output logic [15:0]      pcIn
);
  logic [3:0]  clkCnt_q;
  logic [15:0] pc_q;

  assign instrLast = !cpuHold && (clkCnt_q >= instrLen);
  assign pcIn      = pc_q;

  // Falling edge keeps every change clear of the sampling edge
  always_ff @(negedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clkCnt_q <= 4'h1;
    end else if (cpuHold || instrLast) begin
      clkCnt_q <= 4'h1;
    end else begin
      clkCnt_q <= clkCnt_q + 4'h1;
    end
  end

  always_ff @(negedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pc_q <= 16'h0100;
    end else if (pcLoad) begin
      pc_q <= {10'h000, vectorIdx, 2'h0};
    end else if (instrLast) begin
      pc_q <= pc_q + 16'h0002;
    end
  end
endmodule

// *** testbench/aes_irq_accept_chk.sv ***
/*
  Assertions on the ports of the interrupt acceptance block.
  Assumes a single clock domain and the bind at the foot of this file.
*/
module aes_irq_accept_chk
  import aes_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        instrLast,
  input wire logic        instrTouchesIrqRegs,
  input wire logic        enableIrqInstr,
  input wire logic        disableIrqInstr,
  input wire logic        regWrEn,
  input wire logic        pswRestoreEn,
  input wire logic        globalIrqEnable,
  input wire logic        cpuHold,
  input wire logic        stackWrEn,
  input wire logic        stackWrIsPsw,
  input wire logic [15:0] stackWrData,
  input wire logic        pcLoad,
  input wire logic [3:0]  vectorIdx
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_push_order: assert property (
    stackWrEn && stackWrIsPsw |=> stackWrEn && !stackWrIsPsw ##1 pcLoad)
    else $error("pc push or vector load missing after status push");
  a_push_ie_off: assert property (
    stackWrEn && stackWrIsPsw |-> !globalIrqEnable)
    else $error("enable still set during status push");
  a_hold_span: assert property (
    $rose(cpuHold) |-> cpuHold[*3] ##1 !cpuHold)
    else $error("hold not three cycles");
  a_accept_point: assert property (
    $rose(cpuHold) |-> $past(instrLast) && !$past(instrTouchesIrqRegs))
    else $error("accept off an open boundary");
  a_disabled_nmi: assert property (
    stackWrEn && stackWrIsPsw && !stackWrData[PSW_IE]
      |-> ##2 vectorIdx == VEC_NMI)
    else $error("maskable vectored while disabled");
  a_psw_fixed: assert property (
    stackWrEn && stackWrIsPsw |-> (stackWrData[7:0] & 8'h2e) == 8'h02)
    else $error("pushed status word fixed bits wrong");
  a_ei_sets: assert property (
    enableIrqInstr && !disableIrqInstr && !regWrEn && !pswRestoreEn
      && !instrLast |=> globalIrqEnable)
    else $error("enable instruction ignored");
  a_di_clears: assert property (
    disableIrqInstr && !enableIrqInstr && !regWrEn && !pswRestoreEn
      |=> !globalIrqEnable)
    else $error("disable instruction ignored");
  a_idle_quiet: assert property (
    !cpuHold |-> !stackWrEn && !pcLoad)
    else $error("stack or vector activity while idle");

  c_nmi: cover property (pcLoad && vectorIdx == VEC_NMI);
  c_mask: cover property (pcLoad && vectorIdx != VEC_NMI);
  c_defer: cover property (instrLast && instrTouchesIrqRegs);
endmodule

bind aes_irq_accept aes_irq_accept_chk chk_u (.core_clk, .nrst,
  .instrLast, .instrTouchesIrqRegs, .enableIrqInstr, .disableIrqInstr,
  .regWrEn, .pswRestoreEn, .globalIrqEnable, .cpuHold, .stackWrEn,
  .stackWrIsPsw, .stackWrData, .pcLoad, .vectorIdx);

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for the interrupt acceptance block.
  Assumes the core model and the bound checker are compiled alongside.
*/
module tb_top
  import aes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LEN = 4;

  logic                 core_clk, nrst, nmiReq, regWrEn, regRdEn;
  logic [2:0]           pins;
  logic [NUM_SRC-1:0]   periphReq;
  aes_reg_sel_type      regSel;
  logic [7:0]           regWrData, regRdData, pswRestoreData;
  logic                 enableIrqInstr, disableIrqInstr, pswRestoreEn;
  logic                 aluFlagWe, aluZero, aluAuxCarry, aluCarry;
  logic                 instrLast, instrTouchesIrqRegs, haltWake;
  logic                 globalIrqEnable, cpuHold, stackWrEn;
  logic                 stackWrIsPsw, pcLoad;
  logic [15:0]          pcIn, stackWrData;
  logic [3:0]           vectorIdx, v;
  int                   fail_count, total_checks, cycles, n;

  aes_irq_accept dut_u (.core_clk, .nrst, .extIrqPinA(pins[0]),
    .extIrqPinB(pins[1]), .extIrqPinC(pins[2]), .periphReq, .nmiReq,
    .regSel, .regWrEn, .regRdEn, .regWrData, .regRdData,
    .enableIrqInstr, .disableIrqInstr, .pswRestoreEn, .pswRestoreData,
    .aluFlagWe, .aluZero, .aluAuxCarry, .aluCarry, .instrLast,
    .instrTouchesIrqRegs, .pcIn, .globalIrqEnable, .cpuHold, .stackWrEn,
    .stackWrIsPsw, .stackWrData, .pcLoad, .vectorIdx, .haltWake);
  aes_cpu_model cpu_u (.core_clk, .nrst, .instrLen(4'(LEN)), .cpuHold,
    .pcLoad, .vectorIdx, .instrLast, .pcIn);

  always #12.5 core_clk = ~core_clk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs about 400 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      test_done();
    end
  end

  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic wr(input aes_reg_sel_type s, input logic [7:0] d);
    regSel = s;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge core_clk);
    regWrEn = 1'b0;
  endtask

  task automatic rd(input aes_reg_sel_type s, input logic [7:0] e);
    regSel = s;
    regRdEn = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    chk(regRdData === e, "register read");
  endtask

  task automatic ie(input logic en);
    enableIrqInstr = en;
    disableIrqInstr = !en;
    @(negedge core_clk);
    {enableIrqInstr, disableIrqInstr} = 2'h0;
  endtask

  // Walks one accept sequence; n counts cycles until the first push
  task automatic get_acc();
    logic [15:0] pc;
    n = 0;
    while (stackWrEn !== 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    pc = pcIn;
    chk(stackWrIsPsw === 1'b1 && globalIrqEnable === 1'b0, "psw push");
    @(negedge core_clk);
    chk(stackWrEn === 1'b1 && stackWrData === pc, "pc push");
    @(negedge core_clk);
    chk(pcLoad === 1'b1 && stackWrEn === 1'b0, "vector load");
    v = vectorIdx;
    @(negedge core_clk);
  endtask

  task automatic quiet(input string m);
    logic seen;
    seen = 1'b0;
    repeat (3 * LEN) begin
      @(negedge core_clk);
      seen |= cpuHold;
    end
    chk(seen === 1'b0, m);
  endtask

  task automatic pend(input logic [NUM_SRC-1:0] r, input logic nmi);
    periphReq = r;
    nmiReq = nmi;
    @(negedge core_clk);
    periphReq = '0;
    nmiReq = 1'b0;
  endtask

  task automatic t_regs();
    rd(SEL_EDGE_MODE, 8'h00);
    rd(SEL_PSW, 8'h02);
    rd(SEL_MASK_LOW, 8'hff);
    wr(SEL_PSW, 8'hff);
    rd(SEL_PSW, 8'hd3);
    wr(SEL_PSW, 8'h00);
    {aluZero, aluAuxCarry, aluCarry, aluFlagWe} = 4'hf;
    @(negedge core_clk);
    aluFlagWe = 1'b0;
    rd(SEL_PSW, 8'h53);
    ie(1'b1);
    chk(globalIrqEnable === 1'b1, "enable");
    ie(1'b0);
    chk(globalIrqEnable === 1'b0, "disable");
    pswRestoreData = 8'h80;
    pswRestoreEn = 1'b1;
    @(negedge core_clk);
    pswRestoreEn = 1'b0;
    rd(SEL_PSW, 8'h82);
    wr(SEL_PSW, 8'h00);
    $display("t_regs done");
  endtask

  task automatic t_nmi();
    wr(SEL_MASK_LOW, 8'hef);
    ie(1'b1);
    pend(9'h010, 1'b1);
    get_acc();
    chk(v === VEC_NMI, "nmi first");
    pend(9'h000, 1'b1);
    get_acc();
    chk(v === VEC_NMI, "nmi nested");
    quiet("maskable taken while disabled");
    chk(haltWake === 1'b1, "wake level");
    wr(SEL_REQ_LOW, 8'h00);
    $display("t_nmi done");
  endtask

  task automatic t_prio();
    wr(SEL_MASK_LOW, 8'hcf);
    pend(9'h070, 1'b0);
    ie(1'b1);
    get_acc();
    chk(v === 4'h5, "priority");
    quiet("nested without enable");
    ie(1'b1);
    get_acc();
    chk(v === 4'h6, "pending taken");
    ie(1'b1);
    quiet("masked source taken");
    ie(1'b0);
    wr(SEL_REQ_LOW, 8'h00);
    $display("t_prio done");
  endtask

  task automatic t_timing();
    wr(SEL_MASK_LOW, 8'hef);
    ie(1'b1);
    @(posedge core_clk iff instrLast === 1'b1);
    @(negedge core_clk);
    pend(9'h010, 1'b0);
    get_acc();
    chk(n == LEN - 1 && v === 4'h5, "early flag");
    ie(1'b1);
    @(posedge core_clk iff instrLast === 1'b1);
    repeat (LEN) @(negedge core_clk);
    pend(9'h010, 1'b0);
    get_acc();
    chk(n == LEN, "last clock flag");
    pend(9'h010, 1'b0);
    @(posedge core_clk iff instrLast === 1'b1);
    @(negedge core_clk);
    instrTouchesIrqRegs = 1'b1;
    ie(1'b1);
    repeat (LEN - 1) @(negedge core_clk);
    instrTouchesIrqRegs = 1'b0;
    get_acc();
    chk(n == LEN, "deferred accept");
    $display("t_timing done");
  endtask

  task automatic t_edges();
    logic [7:0] e;
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 4; c++) begin
        wr(SEL_MASK_LOW, 8'hff);
        wr(SEL_EDGE_MODE, 8'(c << (2 + 2 * p)));
        wr(SEL_REQ_LOW, 8'h00);
        pins[p] = 1'b1;
        repeat (6) @(negedge core_clk);
        e = (c == 1 || c == 3) ? 8'(2 << p) : 8'h00;
        rd(SEL_REQ_LOW, e);
        wr(SEL_REQ_LOW, 8'h00);
        pins[p] = 1'b0;
        repeat (6) @(negedge core_clk);
        e = (c == 0 || c == 3) ? 8'(2 << p) : 8'h00;
        rd(SEL_REQ_LOW, e);
      end
    end
    $display("t_edges done");
  endtask

  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    regSel = SEL_EDGE_MODE;
    {pins, periphReq, nmiReq, regWrEn, regRdEn, regWrData} = '0;
    {enableIrqInstr, disableIrqInstr, pswRestoreEn, pswRestoreData} = '0;
    {aluFlagWe, aluZero, aluAuxCarry, aluCarry} = 4'h0;
    instrTouchesIrqRegs = 1'b0;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    t_regs();
    t_nmi();
    t_prio();
    t_timing();
    t_edges();
    test_done();
  end
endmodule
